// File: core/serial_cfg_pkg.sv
// Purpose: Shared constants and carrier types for the serial unit configuration block
// Assumes: Classic Wishbone slave, 8-bit registers in the low byte of 32-bit words
// Notes:   Offsets are byte addresses of word-aligned registers
package serial_cfg_pkg;

  localparam int DIV_W = 13;
  localparam int REG_W = 8;
  localparam int ADDR_W = 5;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_DIV_HIGH  = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_DIV_LOW   = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_FRAME     = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_CONTROL2  = 5'h0c;
  localparam logic [ADDR_W-1:0] OFF_STATUS    = 5'h10;
  localparam logic [ADDR_W-1:0] OFF_STATUS2   = 5'h14;
  localparam logic [ADDR_W-1:0] OFF_CONTROL3  = 5'h18;
  localparam logic [ADDR_W-1:0] OFF_DATA      = 5'h1c;

  // High divisor register fields and low divisor width
  localparam int HI_BRK_IE = 7;
  localparam int HI_EDGE_IE = 6;
  localparam int HI_DIV_MSB = 4;
  localparam int LO_DIV_W = 8;

  // Frame control fields
  localparam int FC_LOOP = 7;
  localparam int FC_SWAI = 6;
  localparam int FC_RECEIVER_SOURCE = 5;
  localparam int FC_NINE = 4;
  localparam int FC_WAKE = 3;
  localparam int FC_ILT = 2;
  localparam int FC_PE = 1;
  localparam int FC_PT = 0;

  // Control register 2 fields
  localparam int C2_TX_ON = 3;
  localparam int C2_RX_ON = 2;

  // Reset values
  localparam logic [REG_W-1:0] RST_DIV_HIGH = 8'h00;
  localparam logic [REG_W-1:0] RST_DIV_LOW  = 8'h04;
  localparam logic [REG_W-1:0] RST_FRAME    = 8'h00;
  localparam logic [REG_W-1:0] RST_ZERO     = 8'h00;

  localparam int OVERSAMPLE = 16;

  typedef struct packed {
    logic loop_select;
    logic stop_in_wait;
    logic receiver_source;
    logic nine_bit;
    logic wake_addr_mark;
    logic idle_after_stop;
    logic parity_on;
    logic parity_odd;
  } frame_cfg_t;

  typedef struct packed {
    logic tx_pin_o;
    logic tx_pin_oe;
    logic rx_pin_owned;
    logic rx_data;
  } pin_route_t;

endpackage

// File: core/serial_baud_gen.sv
// Purpose: Baud tick generator, one tick per divisor bus clocks
// Assumes: Divisor changes take effect at once, the running count is compared with the new value
// Notes:   Idle and clockless while divisor is zero or run_i is low
`timescale 1ns/1ns
module serial_baud_gen #(
  parameter int DIV_W = serial_cfg_pkg::DIV_W
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Control
  input  wire logic             run_i,
  input  wire logic [DIV_W-1:0] divisor_i,
  // Ticks
  output logic                  tick16_o,
  output logic                  bit_tick_o
);

  logic [DIV_W-1:0] count;
  logic [3:0]       phase;
  logic             active;

  assign active = run_i && (divisor_i != '0);

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !active)
    begin
      count    <= '0;
      tick16_o <= 1'b0;
    end
    else if (count >= divisor_i - DIV_W'(1))
    begin
      count    <= '0;
      tick16_o <= 1'b1;
    end
    else
    begin
      count    <= count + DIV_W'(1);
      tick16_o <= 1'b0;
    end
  end

  // Sixteen sampling ticks make one bit time
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !active)
    begin
      phase      <= '0;
      bit_tick_o <= 1'b0;
    end
    else
    begin
      bit_tick_o <= tick16_o && (phase == 4'(serial_cfg_pkg::OVERSAMPLE - 1));
      if (tick16_o)
        phase <= phase + 4'h1;
    end
  end

endmodule

// File: core/serial_parity.sv
// Purpose: Parity generation and check for 8- or 9-bit characters
// Assumes: Parity bit is the most significant data bit
// Notes:   Purely combinational
`timescale 1ns/1ns
module serial_parity (
  // Configuration
  input  wire logic       nine_bit_i,
  input  wire logic       parity_odd_i,
  // Data
  input  wire logic [8:0] tx_data_i,
  input  wire logic [8:0] rx_data_i,
  // Results
  output logic [8:0]      tx_char_o,
  output logic            rx_error_o
);

  logic [7:0] tx_low;
  logic       tx_par;
  logic       rx_ones;

  // Parity over the data bits below the parity position
  assign tx_low = nine_bit_i ? tx_data_i[7:0] : {1'b0, tx_data_i[6:0]};
  assign tx_par = (^tx_low) ^ parity_odd_i;
  assign tx_char_o = nine_bit_i ? {tx_par, tx_data_i[7:0]}
                                : {1'b0, tx_par, tx_data_i[6:0]};
  assign rx_ones = nine_bit_i ? ^rx_data_i : ^rx_data_i[7:0];
  assign rx_error_o = rx_ones ^ parity_odd_i;

endmodule

// File: core/serial_cfg.sv
// Purpose: Baud divisor and frame control registers of the serial unit
// Assumes: Classic Wishbone slave on clk_i, shifters sit outside this block
// Notes:   Ack comes one cycle after the request and drops the cycle after
//
// The Wishbone slave port and the register offsets were left to the implementer.
`timescale 1ns/1ns
module serial_cfg #(
  parameter int DIV_W = serial_cfg_pkg::DIV_W
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [4:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // System state
  input  wire logic        wait_mode_i,
  // Status from shifters
  input  wire logic        break_detect_flag_i,
  input  wire logic        rx_edge_flag_i,
  input  wire logic [7:0]  status_i,
  input  wire logic [7:0]  status2_i,
  input  wire logic [8:0]  rx_char_i,
  input  wire logic        tx_serial_i,
  // Pins
  input  wire logic        rx_pin_i,
  input  wire logic        tx_pin_i,
  output logic             tx_pin_o,
  output logic             tx_pin_oe_o,
  output logic             rx_pin_owned_o,
  // To shifters
  output logic             unit_clk_run_o,
  output logic             tick16_o,
  output logic             bit_tick_o,
  output logic             rx_data_o,
  output serial_cfg_pkg::frame_cfg_t frame_o,
  output logic [7:0]       control2_o,
  output logic [7:0]       control3_o,
  output logic [7:0]       tx_data_o,
  output logic             tx_load_o,
  output logic             rx_read_o,
  output logic [8:0]       tx_char_o,
  output logic             rx_parity_err_o,
  output logic             irq_o
);

  logic [7:0]       div_high;
  logic [4:0]       div_high_buf;
  logic [7:0]       div_low;
  logic [DIV_W-1:0] divisor_value;
  logic [7:0]       frame;
  logic [7:0]       control2;
  logic [7:0]       control3;
  logic [7:0]       tx_data;
  logic             baud_armed;
  logic             rx_meta;
  logic             rx_sync;
  logic             txp_meta;
  logic             txp_sync;
  logic             req;
  logic             wr_low;
  logic [7:0]       next_read;
  logic             rx_mux;
  logic [8:0]       raw_char;
  logic [8:0]       par_char;

  assign req    = cyc_i && stb_i && !ack_o;
  assign wr_low = req && we_i && sel_i[0];

  function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
    hit = (a == off);
  endfunction

  // Bus handshake, one wait state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_o <= 1'b0;
    else
      ack_o <= req;
  end

  // High half kept in a buffer until the low half lands
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div_high     <= serial_cfg_pkg::RST_DIV_HIGH;
      div_high_buf <= serial_cfg_pkg::RST_DIV_HIGH[4:0];
    end
    else if (wr_low && hit(adr_i, serial_cfg_pkg::OFF_DIV_HIGH))
    begin
      div_high     <= {dat_i[7:6], 1'b0, div_high[4:0]};
      div_high_buf <= dat_i[serial_cfg_pkg::HI_DIV_MSB:0];
    end
    else if (wr_low && hit(adr_i, serial_cfg_pkg::OFF_DIV_LOW))
      div_high[4:0] <= div_high_buf;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      div_low <= serial_cfg_pkg::RST_DIV_LOW;
    else if (wr_low && hit(adr_i, serial_cfg_pkg::OFF_DIV_LOW))
      div_low <= dat_i[7:0];
  end

  assign divisor_value = {div_high[4:0], div_low};

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      frame <= serial_cfg_pkg::RST_FRAME;
    else if (wr_low && hit(adr_i, serial_cfg_pkg::OFF_FRAME))
      frame <= dat_i[7:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      control2 <= serial_cfg_pkg::RST_ZERO;
    else if (wr_low && hit(adr_i, serial_cfg_pkg::OFF_CONTROL2))
      control2 <= dat_i[7:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      control3 <= serial_cfg_pkg::RST_ZERO;
    else if (wr_low && hit(adr_i, serial_cfg_pkg::OFF_CONTROL3))
      control3 <= dat_i[7:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      tx_data <= serial_cfg_pkg::RST_ZERO;
    else if (wr_low && hit(adr_i, serial_cfg_pkg::OFF_DATA))
      tx_data <= dat_i[7:0];
  end

  // Baud generator stays idle until an enable is first written to one
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      baud_armed <= 1'b0;
    else if (wr_low && hit(adr_i, serial_cfg_pkg::OFF_CONTROL2)
             && (dat_i[serial_cfg_pkg::C2_TX_ON] || dat_i[serial_cfg_pkg::C2_RX_ON]))
      baud_armed <= 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      tx_load_o <= 1'b0;
    else
      tx_load_o <= wr_low && hit(adr_i, serial_cfg_pkg::OFF_DATA);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rx_read_o <= 1'b0;
    else
      rx_read_o <= req && !we_i && hit(adr_i, serial_cfg_pkg::OFF_DATA);
  end

  // Read mux, eight byte-wide registers
  always_comb
  begin
    next_read = serial_cfg_pkg::RST_ZERO;
    unique case (adr_i)
      serial_cfg_pkg::OFF_DIV_HIGH: next_read = div_high;
      serial_cfg_pkg::OFF_DIV_LOW:  next_read = div_low;
      serial_cfg_pkg::OFF_FRAME:    next_read = frame;
      serial_cfg_pkg::OFF_CONTROL2: next_read = control2;
      serial_cfg_pkg::OFF_STATUS:   next_read = status_i;
      serial_cfg_pkg::OFF_STATUS2:  next_read = status2_i;
      serial_cfg_pkg::OFF_CONTROL3: next_read = {rx_char_i[8], control3[6:0]};
      serial_cfg_pkg::OFF_DATA:     next_read = rx_char_i[7:0];
      default:                      next_read = serial_cfg_pkg::RST_ZERO;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= '0;
    else if (req && !we_i)
      dat_o <= {24'h000000, next_read};
    else
      dat_o <= '0;
  end

  // Pin synchronisers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end
    else
    begin
      rx_meta <= rx_pin_i;
      rx_sync <= rx_meta;
    end
  end

  // Transmit pin read back for single-wire receive
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      txp_meta <= 1'b1;
      txp_sync <= 1'b1;
    end
    else
    begin
      txp_meta <= tx_pin_i;
      txp_sync <= txp_meta;
    end
  end

  // Receiver input routing
  always_comb
  begin
    if (!frame[serial_cfg_pkg::FC_LOOP])
      rx_mux = rx_sync;
    else if (frame[serial_cfg_pkg::FC_RECEIVER_SOURCE])
      rx_mux = txp_sync;
    else
      rx_mux = tx_serial_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rx_data_o <= 1'b1;
    else
      rx_data_o <= rx_mux;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_pin_o    <= 1'b1;
      tx_pin_oe_o <= 1'b0;
    end
    else
    begin
      tx_pin_o    <= tx_serial_i;
      tx_pin_oe_o <= control2[serial_cfg_pkg::C2_TX_ON];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rx_pin_owned_o <= 1'b0;
    else
      rx_pin_owned_o <= control2[serial_cfg_pkg::C2_RX_ON]
                        && !frame[serial_cfg_pkg::FC_LOOP];
  end

  // Clocks freeze in wait mode only when asked to
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      unit_clk_run_o <= 1'b1;
    else
      unit_clk_run_o <= !(wait_mode_i && frame[serial_cfg_pkg::FC_SWAI]);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= (div_high[serial_cfg_pkg::HI_BRK_IE] && break_detect_flag_i)
               || (div_high[serial_cfg_pkg::HI_EDGE_IE] && rx_edge_flag_i);
  end

  // Frame options passed to the shifters
  assign frame_o = serial_cfg_pkg::frame_cfg_t'(frame);
  assign control2_o = control2;
  assign control3_o = control3;
  assign tx_data_o  = tx_data;

  serial_baud_gen #(
    .DIV_W(DIV_W)
  ) u_baud (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .run_i      (baud_armed && unit_clk_run_o),
    .divisor_i  (divisor_value),
    .tick16_o   (tick16_o),
    .bit_tick_o (bit_tick_o)
  );

  logic par_err;

  serial_parity u_parity (
    .nine_bit_i   (frame[serial_cfg_pkg::FC_NINE]),
    .parity_odd_i (frame[serial_cfg_pkg::FC_PT]),
    .tx_data_i    ({control3[6], tx_data}),
    .rx_data_i    (rx_char_i),
    .tx_char_o    (par_char),
    .rx_error_o   (par_err)
  );

  assign rx_parity_err_o = frame[serial_cfg_pkg::FC_PE] && par_err;

  // Without parity the character goes out exactly as software wrote it
  assign raw_char  = frame[serial_cfg_pkg::FC_NINE] ? {control3[6], tx_data}
                                                    : {1'b0, tx_data};
  assign tx_char_o = frame[serial_cfg_pkg::FC_PE] ? par_char : raw_char;

endmodule

// File: verification/serial_cfg_checker.sv
// Purpose: Port-level checks of the serial unit configuration block
// Assumes: Single clock domain, synchronous active-high reset
// Notes:   Attached to every serial_cfg instance by bind
`timescale 1ns/1ns
module serial_cfg_checker (
  // Clock, reset and bus
  input wire logic                       clk_i,
  input wire logic                       rst_i,
  input wire logic                       cyc_i,
  input wire logic                       stb_i,
  input wire logic                       ack_o,
  // Inputs seen
  input wire logic                       wait_mode_i,
  input wire logic                       break_detect_flag_i,
  input wire logic                       rx_edge_flag_i,
  input wire logic                       tx_serial_i,
  // Outputs watched
  input wire serial_cfg_pkg::frame_cfg_t frame_o,
  input wire logic [7:0]                 control2_o,
  input wire logic                       tx_pin_oe_o,
  input wire logic                       rx_pin_owned_o,
  input wire logic                       unit_clk_run_o,
  input wire logic                       rx_data_o,
  input wire logic [8:0]                 tx_char_o,
  input wire logic                       rx_parity_err_o,
  input wire logic                       irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_ans;
    ack_o ##1 !ack_o;
  endsequence
  a_ack_after_req: assert property (s_req |=> s_ans)
    else $error("ack not one cycle after request");
  a_ack_has_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  a_irq_idle_low: assert property (!break_detect_flag_i && !rx_edge_flag_i |=> !irq_o)
    else $error("irq without flag");
  a_clk_freeze: assert property (unit_clk_run_o == !$past(wait_mode_i && frame_o.stop_in_wait))
    else $error("unit clock run wrong");
  a_rx_release: assert property (rx_pin_owned_o == $past(control2_o[2] && !frame_o.loop_select))
    else $error("receive pin ownership wrong");
  a_tx_drive: assert property ($rose(tx_pin_oe_o) |-> control2_o[3])
    else $error("transmit pin driven while off");
  a_loop_route: assert property (frame_o.loop_select && !frame_o.receiver_source && $stable(frame_o)
    |-> rx_data_o == $past(tx_serial_i))
    else $error("loop-back routing wrong");
  a_parity_eight: assert property (frame_o.parity_on && !frame_o.nine_bit
    |-> (^tx_char_o[7:0]) == frame_o.parity_odd)
    else $error("8-bit parity wrong");
  a_parity_nine: assert property (frame_o.parity_on && frame_o.nine_bit
    |-> (^tx_char_o) == frame_o.parity_odd)
    else $error("9-bit parity wrong");
  a_no_perr: assert property (!frame_o.parity_on |-> !rx_parity_err_o)
    else $error("parity error while parity off");
endmodule

bind serial_cfg serial_cfg_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .ack_o(ack_o), .wait_mode_i(wait_mode_i),
  .break_detect_flag_i(break_detect_flag_i), .rx_edge_flag_i(rx_edge_flag_i),
  .tx_serial_i(tx_serial_i), .frame_o(frame_o), .control2_o(control2_o),
  .tx_pin_oe_o(tx_pin_oe_o), .rx_pin_owned_o(rx_pin_owned_o), .unit_clk_run_o(unit_clk_run_o),
  .rx_data_o(rx_data_o), .tx_char_o(tx_char_o), .rx_parity_err_o(rx_parity_err_o),
  .irq_o(irq_o));

// File: verification/serial_far_end.sv
// Purpose: Remote transceiver on the shared serial lines
// Assumes: Both lines pulled up when nobody drives them
// Notes:   Sends the complement on its own line so the two sources differ
`timescale 1ns/1ns
module serial_far_end (
  // Unit side of the transmit wire
  input  wire logic line_oe_i,
  input  wire logic line_i,
  // Far end drive
  input  wire logic drive_i,
  input  wire logic bit_i,
  // Resolved lines
  output logic      rx_pin_o,
  output logic      tx_wire_o
);
  assign rx_pin_o = drive_i ? ~bit_i : 1'b1;
  // Unit wins the shared wire while enabled, else far end, else pull-up
  assign tx_wire_o = line_oe_i ? line_i : (drive_i ? bit_i : 1'b1);
endmodule

// File: verification/serial_cfg_tb.sv
// Purpose: Register and routing test of the serial unit configuration block
// Assumes: One request at a time, ack awaited under a bound
// Notes:   Divisors kept small so tick counts are exact
`timescale 1ns/1ns
module serial_cfg_tb;
  logic clk_i, rst_i, cyc, stb, we, wait_m, brk, edg, txs, far_drv, far_bit;
  logic [4:0] adr;
  logic [31:0] dat, dat_o;
  logic ack_o, tx_pin_o, oe, owned, run, t16, bt, rxd, perr, irq, rx_pin, tx_wire, ld, rr;
  logic [7:0] c2, c3, txd;
  logic [8:0] tx_char;
  serial_cfg_pkg::frame_cfg_t frame;
  int fail_count, comparisons, nt, nb;
  logic [7:0] fv [4] = '{8'h02, 8'h03, 8'h12, 8'h13};
  logic [8:0] pv [4] = '{9'h003, 9'h083, 9'h003, 9'h103};

  serial_cfg i_serial_cfg (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'h1), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
    .wait_mode_i(wait_m), .break_detect_flag_i(brk), .rx_edge_flag_i(edg),
    .status_i(8'h00), .status2_i(8'h00), .rx_char_i(9'h003), .tx_serial_i(txs),
    .rx_pin_i(rx_pin), .tx_pin_i(tx_wire), .tx_pin_o(tx_pin_o), .tx_pin_oe_o(oe),
    .rx_pin_owned_o(owned), .unit_clk_run_o(run), .tick16_o(t16), .bit_tick_o(bt),
    .rx_data_o(rxd), .frame_o(frame), .control2_o(c2), .control3_o(c3), .tx_data_o(txd),
    .tx_load_o(ld), .rx_read_o(rr), .tx_char_o(tx_char), .rx_parity_err_o(perr), .irq_o(irq));
  serial_far_end i_far (.line_oe_i(oe), .line_i(tx_pin_o), .drive_i(far_drv),
    .bit_i(far_bit), .rx_pin_o(rx_pin), .tx_wire_o(tx_wire));

  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic close_out;
    if (fail_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d,
                    output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 16);
    if (ack_o !== 1'b1)
    begin
      fail_count++;
      close_out();
    end
    q = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk({24'h0, q}, {24'h0, e});
  endtask

  task automatic ticks(input int win);
    nt = 0;
    nb = 0;
    repeat (win)
    begin
      @(posedge clk_i);
      nt += int'(t16 === 1'b1);
      nb += int'(bt === 1'b1);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  initial
  begin
    {rst_i, cyc, stb, we, wait_m, brk, edg, txs, far_drv, far_bit} = 10'h200;
    adr = 5'h00;
    dat = 32'h0;
    idle(4);
    rst_i <= 1'b0;
    rd(5'h00, 8'h00);
    rd(5'h04, 8'h04);
    rd(5'h08, 8'h00);
    rd(5'h03, 8'h00);
    ticks(40);
    chk(nt, 0);
    wr(5'h0c, 8'h0c);
    ticks(64);
    chk(nt, 16);
    chk(oe, 1'b1);
    chk(owned, 1'b1);
    wr(5'h00, 8'hc1);
    rd(5'h00, 8'hc0);
    ticks(64);
    chk(nt, 16);
    wr(5'h00, 8'h00);
    wr(5'h04, 8'h02);
    rd(5'h04, 8'h02);
    ticks(64);
    chk({nt[15:0], nb[15:0]}, {16'd32, 16'd2});
    wr(5'h00, 8'hc0);
    wr(5'h04, 8'h00);
    rd(5'h00, 8'hc0);
    ticks(64);
    chk(nt, 0);
    brk <= 1'b1;
    idle(3);
    chk(irq, 1'b1);
    brk <= 1'b0;
    edg <= 1'b1;
    idle(3);
    chk(irq, 1'b1);
    wr(5'h00, 8'h00);
    brk <= 1'b1;
    idle(3);
    chk(irq, 1'b0);
    {brk, edg} <= 2'b00;
    far_drv <= 1'b1;
    idle(5);
    chk(rxd, 1'b1);
    wr(5'h08, 8'h80);
    idle(1);
    chk(owned, 1'b0);
    txs <= 1'b0;
    idle(3);
    chk(rxd, 1'b0);
    txs <= 1'b1;
    idle(3);
    chk(rxd, 1'b1);
    chk(tx_pin_o, 1'b1);
    wr(5'h08, 8'ha0);
    wr(5'h0c, 8'h04);
    idle(1);
    chk(oe, 1'b0);
    idle(5);
    chk(rxd, 1'b0);
    far_bit <= 1'b1;
    idle(5);
    chk(rxd, 1'b1);
    wait_m <= 1'b1;
    idle(3);
    chk(run, 1'b1);
    wr(5'h08, 8'h40);
    idle(3);
    chk(run, 1'b0);
    wr(5'h08, 8'hff);
    rd(5'h08, 8'hff);
    chk(frame, 8'hff);
    wr(5'h08, 8'h08);
    chk(frame.wake_addr_mark, 1'b1);
    wr(5'h08, 8'h04);
    chk(frame.idle_after_stop, 1'b1);
    wr(5'h1c, 8'h03);
    chk(ld, 1'b1);
    chk(txd, 8'h03);
    for (int i = 0; i < 4; i++)
    begin
      wr(5'h08, fv[i]);
      chk(tx_char, pv[i]);
      chk(perr, fv[i][0]);
      chk(frame.nine_bit, fv[i][4]);
    end
    wr(5'h1c, 8'h83);
    wr(5'h08, 8'h00);
    chk(tx_char, 9'h083);
    chk(perr, 1'b0);
    rd(5'h1c, 8'h03);
    chk(rr, 1'b1);
    wr(5'h18, 8'h40);
    chk(c3, 8'h40);
    rd(5'h18, 8'h40);
    close_out();
  end
endmodule
